// ---- verilog/sers_defines.vh ----
// Bit positions, read selects, enable write selects and reset values for the status register sets
`ifndef SERS_DEFINES_VH
`define SERS_DEFINES_VH

// Standard event bit positions
`define SERS_STD_OPS_DONE     0
`define SERS_STD_EMPTY_READ   2
`define SERS_STD_BACKUP_MEM   3
`define SERS_STD_RUN_FAULT    4
`define SERS_STD_INSTR_FAULT  5
`define SERS_STD_LOCAL_REQ    6
`define SERS_STD_POWER_CYC    7

// Operation bit positions
`define SERS_OPR_CONVERTING   4
`define SERS_OPR_AWAIT_START  5
`define SERS_OPR_SMOOTHED     8
`define SERS_OPR_IDLE         10

// Measurement bit positions
`define SERS_MEA_OVER_RANGE   0
`define SERS_MEA_LOW_ONE      1
`define SERS_MEA_HIGH_ONE     2
`define SERS_MEA_LOW_TWO      3
`define SERS_MEA_HIGH_TWO     4
`define SERS_MEA_READY        5
`define SERS_MEA_NOTIFY       6
`define SERS_MEA_TWO_READY    7
`define SERS_MEA_HALF         8
`define SERS_MEA_COMPLETE     9
`define SERS_MEA_WRAPPED      10
`define SERS_MEA_HW_BOUND     11
`define SERS_MEA_QUARTER      12
`define SERS_MEA_THREE_QTR    13
`define SERS_MEA_ANY_BOUND    14

// Questionable bit positions
`define SERS_QUE_JUNCTION     4
`define SERS_QUE_TRIM         8
`define SERS_QUE_IGNORED      14

// Register read select codes
`define SERS_SEL_STD_EVENT    3'h0
`define SERS_SEL_OPR_EVENT    3'h1
`define SERS_SEL_MEA_EVENT    3'h2
`define SERS_SEL_QUE_EVENT    3'h3
`define SERS_SEL_OPR_COND     3'h4
`define SERS_SEL_MEA_COND     3'h5
`define SERS_SEL_QUE_COND     3'h6

// Enable write select codes
`define SERS_EN_STD           2'h0
`define SERS_EN_OPR           2'h1
`define SERS_EN_MEA           2'h2
`define SERS_EN_QUE           2'h3

// Reset values, one bit, replicated to register width
`define SERS_EVENT_RESET      1'h0
`define SERS_ENABLE_RESET     1'h0

`endif

// ---- verilog/sers_event_set.v ----
// One latched event register with read-clear, enable mask and summary
`timescale 1ns/1ns
`include "sers_defines.vh"

module sers_event_set #(
   parameter WIDTH = 16
) (
   input  wire             i_mclk,
   input  wire             i_srst,
   input  wire [WIDTH-1:0] i_set,
   input  wire             i_read_clr,
   input  wire             i_clear_all,
   input  wire [WIDTH-1:0] i_enable,
   output reg  [WIDTH-1:0] o_event,
   output reg              o_summary
);

   reg [WIDTH-1:0] next_event;

   // Set wins over read-clear and clear-all
   always @* begin
      if (i_read_clr || i_clear_all) begin
         next_event = i_set;
      end else begin
         next_event = o_event | i_set;
      end
   end

   // Event latch
   always @(posedge i_mclk) begin
      if (i_srst) begin
         o_event <= {WIDTH{`SERS_EVENT_RESET}};
      end else begin
         o_event <= next_event;
      end
   end

   // Summary follows latched events and enables at once
   always @* begin
      o_summary = |(o_event & i_enable);
   end

endmodule

// ---- verilog/sers_status_sets.v ----
// Four status register sets: standard, operation, measurement, questionable
// Notes on behaviour
// - Ops-done sets only when completion query seen and pending operations finished.
// - Empty-read error sets when a response read hits an empty output queue.
// - Backup-memory error sets on cannot-resume-scan or lost-backup-data errors.
// - Run-fault sets on error while executing a received command.
// - Instrument-fault sets on failed instrument operation; placed at bit 5.
// - Local-request sets when front-panel local key press input asserts.
// - Power-cycled sets after each power-up, stays until standard register read or clear-all.
// - Operation bits: converting 4, awaiting start 5, smoothed 8, idle 10.
// - Over-range at measurement bit 0, hardware bound exceeded at bit 11.
// - Bits 1..4 flag the four bounds; bit 14 flags any bound reached.
// - Reading-ready at bit 5 whenever a reading is taken and processed.
// - Buffer-count-notify at bit 6 when stored count reaches notify count.
// - Buffer-two-ready at bit 7 when buffer holds two or more readings.
// - Fill levels: quarter 12, half 8, three quarter 13, complete 9.
// - Buffer-wrapped at bit 10 when a full buffer overwrites readings.
// - Questionable bit 4 junction reference invalid, bit 14 parameter ignored.
// - Questionable bit 8 for bad trim constant, persists until calibration done.
// - Operation, measurement, questionable have live read-only condition registers.
// - Event bits latch to one and hold until the register is read, cleared or reset.
// - Reading an event register clears all its bits except those set in the same cycle.
// - Power-up and clear-all zero event registers; status-defaults leaves them.
// - Each set's summary is one when any event AND enable bit is one.
// - Enable registers 16 bits (standard 8 bits), zeroed by power-up and status-defaults only.
`timescale 1ns/1ns
`include "sers_defines.vh"

module sers_status_sets #(
   parameter CNT_W = 16
) (
   input  wire             i_mclk,
   input  wire             i_srst,
   // Standard event causes, one-cycle pulses from the command engine; i_ops_pending is a level, i_local_key an unsynchronised front-panel input
   input  wire             i_completion_query,
   input  wire             i_ops_pending,
   input  wire             i_empty_read_error,
   input  wire             i_err_resume_scan,
   input  wire             i_err_backup_lost,
   input  wire             i_run_fault,
   input  wire             i_err_setup_mismatch,
   input  wire             i_err_module_comm,
   input  wire             i_err_module_unsupported,
   input  wire             i_local_key,
   // Operation conditions, levels
   input  wire             i_converting,
   input  wire             i_await_start,
   input  wire             i_smoothing_settled,
   input  wire             i_smoothing_off,
   input  wire             i_idle,
   // Measurement sources
   input  wire             i_over_range,
   input  wire [3:0]       i_bound_hit,
   input  wire             i_hw_bound,
   input  wire             i_reading_done,
   input  wire             i_buffer_store,
   input  wire             i_buffer_clear,
   input  wire [CNT_W-1:0] i_buffer_size,
   input  wire [CNT_W-1:0] i_notify_count,
   // Questionable conditions
   input  wire             i_junction_invalid,
   input  wire             i_trim_invalid,
   input  wire             i_calibration_ok,
   input  wire             i_param_ignored,
   // Host command strobes
   input  wire             i_clear_all,
   input  wire             i_status_defaults,
   input  wire             i_enable_wr,
   input  wire [1:0]       i_enable_sel,
   input  wire [15:0]      i_enable_data,
   input  wire             i_read,
   input  wire [2:0]       i_read_sel,
   // Outputs
   output reg  [15:0]      o_read_data,
   output reg              o_read_valid,
   output reg              o_use_default_trim,
   output reg  [3:0]       o_summary
);

   // ****************************************
   // Local declarations
   // ****************************************
   reg  [1:0]       local_sync;
   reg              local_prev;
   reg              power_cycled;
   reg              query_wait;
   reg              trim_bad;
   reg  [CNT_W-1:0] fill_count;
   reg              wrapped_pend;
   reg  [7:0]       en_std;
   reg  [15:0]      en_opr;
   reg  [15:0]      en_mea;
   reg  [15:0]      en_que;
   reg  [15:0]      opr_cond;
   reg  [15:0]      mea_cond;
   reg  [15:0]      que_cond;
   reg  [15:0]      mea_prev;
   reg  [15:0]      opr_prev;
   reg  [15:0]      que_prev;
   reg  [7:0]       std_set;
   reg  [15:0]      mea_pulse;
   wire [7:0]       std_event;
   wire [15:0]      opr_event;
   wire [15:0]      mea_event;
   wire [15:0]      que_event;
   wire [3:0]       summary_w;
   wire [3:0]       read_clr;
   wire             ops_done_now;
   wire             local_edge;
   wire             buffer_full;
   wire [CNT_W+1:0] fill_x4;
   wire [CNT_W+1:0] size_x1;
   wire [CNT_W+1:0] size_x2;
   wire [CNT_W+1:0] size_x3;

   // Read select decode used by several sets
   function rd_hit;
      input       rd;
      input [2:0] sel;
      input [2:0] code;
      begin
         rd_hit = rd && (sel == code);
      end
   endfunction

   // ****************************************
   // Standard event sources
   // ****************************************

   // Local key synchroniser and edge
   always @(posedge i_mclk) begin
      if (i_srst) begin
         local_sync <= 2'h0;
         local_prev <= 1'b0;
      end else begin
         local_sync <= {local_sync[0], i_local_key};
         local_prev <= local_sync[1];
      end
   end
   assign local_edge = local_sync[1] & ~local_prev;

   // Completion query waits for pending operations to drain
   always @(posedge i_mclk) begin
      if (i_srst) begin
         query_wait <= 1'b0;
      end else if (ops_done_now) begin
         query_wait <= 1'b0;
      end else if (i_completion_query) begin
         query_wait <= 1'b1;
      end
   end
   assign ops_done_now = (i_completion_query | query_wait) & ~i_ops_pending;

   // Power-cycled set once in the first cycle after reset
   always @(posedge i_mclk) begin
      if (i_srst) begin
         power_cycled <= 1'b1;
      end else begin
         power_cycled <= 1'b0;
      end
   end

   // Standard event set vector
   always @* begin
      std_set = 8'h00;
      std_set[`SERS_STD_OPS_DONE]    = ops_done_now;
      std_set[`SERS_STD_EMPTY_READ]  = i_empty_read_error;
      std_set[`SERS_STD_BACKUP_MEM]  = i_err_resume_scan | i_err_backup_lost;
      std_set[`SERS_STD_RUN_FAULT]   = i_run_fault;
      std_set[`SERS_STD_INSTR_FAULT] = i_err_setup_mismatch | i_err_module_comm
                                       | i_err_module_unsupported;
      std_set[`SERS_STD_LOCAL_REQ]   = local_edge;
      std_set[`SERS_STD_POWER_CYC]   = power_cycled;
   end

   // ****************************************
   // Buffer fill tracking
   // ****************************************

   // Stored count saturates at buffer size, wrap pulses on overwrite
   always @(posedge i_mclk) begin
      if (i_srst || i_buffer_clear) begin
         fill_count   <= {CNT_W{1'b0}};
         wrapped_pend <= 1'b0;
      end else if (i_buffer_store) begin
         if (buffer_full) begin
            wrapped_pend <= 1'b1;
         end else begin
            fill_count   <= fill_count + {{(CNT_W-1){1'b0}}, 1'b1};
            wrapped_pend <= 1'b0;
         end
      end else begin
         wrapped_pend <= 1'b0;
      end
   end
   assign buffer_full = (i_buffer_size != {CNT_W{1'b0}}) && (fill_count >= i_buffer_size);
   assign fill_x4 = {fill_count, 2'b00};
   assign size_x1 = {2'b00, i_buffer_size};
   assign size_x2 = {1'b0, i_buffer_size, 1'b0};
   assign size_x3 = size_x1 + size_x2;

   // ****************************************
   // Condition registers
   // ****************************************

   // Trim constant fault holds until a good calibration
   always @(posedge i_mclk) begin
      if (i_srst) begin
         trim_bad           <= 1'b0;
         o_use_default_trim <= 1'b0;
      end else begin
         if (i_calibration_ok) begin
            trim_bad <= 1'b0;
         end else if (i_trim_invalid) begin
            trim_bad <= 1'b1;
         end
         o_use_default_trim <= ~i_calibration_ok & (trim_bad | i_trim_invalid);
      end
   end

   // Live conditions, unused bits read zero
   always @(posedge i_mclk) begin
      if (i_srst) begin
         opr_cond <= 16'h0000;
         mea_cond <= 16'h0000;
         que_cond <= 16'h0000;
      end else begin
         opr_cond <= 16'h0000;
         opr_cond[`SERS_OPR_CONVERTING]  <= i_converting;
         opr_cond[`SERS_OPR_AWAIT_START] <= i_await_start;
         opr_cond[`SERS_OPR_SMOOTHED]    <= i_smoothing_settled | i_smoothing_off;
         opr_cond[`SERS_OPR_IDLE]        <= i_idle;
         mea_cond <= 16'h0000;
         mea_cond[`SERS_MEA_OVER_RANGE]  <= i_over_range;
         mea_cond[`SERS_MEA_HIGH_TWO:`SERS_MEA_LOW_ONE] <= i_bound_hit;
         mea_cond[`SERS_MEA_ANY_BOUND]   <= |i_bound_hit;
         mea_cond[`SERS_MEA_HW_BOUND]    <= i_hw_bound;
         mea_cond[`SERS_MEA_NOTIFY]      <= (i_notify_count != {CNT_W{1'b0}})
                                            && (fill_count >= i_notify_count);
         mea_cond[`SERS_MEA_TWO_READY]   <= fill_count >= {{(CNT_W-2){1'b0}}, 2'h2};
         mea_cond[`SERS_MEA_QUARTER]     <= (i_buffer_size != {CNT_W{1'b0}})
                                            && (fill_x4 >= size_x1);
         mea_cond[`SERS_MEA_HALF]        <= (i_buffer_size != {CNT_W{1'b0}})
                                            && (fill_x4 >= size_x2);
         mea_cond[`SERS_MEA_THREE_QTR]   <= (i_buffer_size != {CNT_W{1'b0}})
                                            && (fill_x4 >= size_x3);
         mea_cond[`SERS_MEA_COMPLETE]    <= buffer_full;
         que_cond <= 16'h0000;
         que_cond[`SERS_QUE_JUNCTION]    <= i_junction_invalid;
         que_cond[`SERS_QUE_TRIM]        <= trim_bad;
         que_cond[`SERS_QUE_IGNORED]     <= i_param_ignored;
      end
   end

   // Previous conditions for rising-edge events
   always @(posedge i_mclk) begin
      if (i_srst) begin
         opr_prev <= 16'h0000;
         mea_prev <= 16'h0000;
         que_prev <= 16'h0000;
      end else begin
         opr_prev <= opr_cond;
         mea_prev <= mea_cond;
         que_prev <= que_cond;
      end
   end

   // Pulse-type measurement events
   always @* begin
      mea_pulse = 16'h0000;
      mea_pulse[`SERS_MEA_READY]   = i_reading_done;
      mea_pulse[`SERS_MEA_WRAPPED] = wrapped_pend;
   end

   // ****************************************
   // Enable registers
   // ****************************************
   always @(posedge i_mclk) begin
      if (i_srst || i_status_defaults) begin
         en_std <= {8{`SERS_ENABLE_RESET}};
         en_opr <= {16{`SERS_ENABLE_RESET}};
         en_mea <= {16{`SERS_ENABLE_RESET}};
         en_que <= {16{`SERS_ENABLE_RESET}};
      end else if (i_enable_wr) begin
         case (i_enable_sel)
            `SERS_EN_STD: en_std <= i_enable_data[7:0];
            `SERS_EN_OPR: en_opr <= i_enable_data;
            `SERS_EN_MEA: en_mea <= i_enable_data;
            default:      en_que <= i_enable_data;
         endcase
      end
   end

   // ****************************************
   // Event sets
   // ****************************************
   assign read_clr[0] = rd_hit(i_read, i_read_sel, `SERS_SEL_STD_EVENT);
   assign read_clr[1] = rd_hit(i_read, i_read_sel, `SERS_SEL_OPR_EVENT);
   assign read_clr[2] = rd_hit(i_read, i_read_sel, `SERS_SEL_MEA_EVENT);
   assign read_clr[3] = rd_hit(i_read, i_read_sel, `SERS_SEL_QUE_EVENT);

   sers_event_set #(.WIDTH(8)) u_std (
      .i_mclk      (i_mclk),
      .i_srst      (i_srst),
      .i_set       (std_set),
      .i_read_clr  (read_clr[0]),
      .i_clear_all (i_clear_all),
      .i_enable    (en_std),
      .o_event     (std_event),
      .o_summary   (summary_w[0])
   );

   sers_event_set #(.WIDTH(16)) u_opr (
      .i_mclk      (i_mclk),
      .i_srst      (i_srst),
      .i_set       (opr_cond & ~opr_prev),
      .i_read_clr  (read_clr[1]),
      .i_clear_all (i_clear_all),
      .i_enable    (en_opr),
      .o_event     (opr_event),
      .o_summary   (summary_w[1])
   );

   sers_event_set #(.WIDTH(16)) u_mea (
      .i_mclk      (i_mclk),
      .i_srst      (i_srst),
      .i_set       ((mea_cond & ~mea_prev) | mea_pulse),
      .i_read_clr  (read_clr[2]),
      .i_clear_all (i_clear_all),
      .i_enable    (en_mea),
      .o_event     (mea_event),
      .o_summary   (summary_w[2])
   );

   sers_event_set #(.WIDTH(16)) u_que (
      .i_mclk      (i_mclk),
      .i_srst      (i_srst),
      .i_set       (que_cond & ~que_prev),
      .i_read_clr  (read_clr[3]),
      .i_clear_all (i_clear_all),
      .i_enable    (en_que),
      .o_event     (que_event),
      .o_summary   (summary_w[3])
   );

   // ****************************************
   // Read port and summaries
   // ****************************************
   always @(posedge i_mclk) begin
      if (i_srst) begin
         o_read_data  <= 16'h0000;
         o_read_valid <= 1'b0;
         o_summary    <= 4'h0;
      end else begin
         o_summary    <= summary_w;
         o_read_valid <= i_read;
         if (i_read) begin
            case (i_read_sel)
               `SERS_SEL_STD_EVENT: o_read_data <= {8'h00, std_event};
               `SERS_SEL_OPR_EVENT: o_read_data <= opr_event;
               `SERS_SEL_MEA_EVENT: o_read_data <= mea_event;
               `SERS_SEL_QUE_EVENT: o_read_data <= que_event;
               `SERS_SEL_OPR_COND:  o_read_data <= opr_cond;
               `SERS_SEL_MEA_COND:  o_read_data <= mea_cond;
               `SERS_SEL_QUE_COND:  o_read_data <= que_cond;
               default:             o_read_data <= 16'h0000;
            endcase
         end
      end
   end

endmodule

// ---- tb/sers_status_sets_properties.sv ----
// Port level checks for the status register sets
`timescale 1ns/1ns
module sers_status_sets_properties (
   input wire        i_mclk,
   input wire        i_srst,
   input wire        i_converting,
   input wire        i_await_start,
   input wire        i_smoothing_settled,
   input wire        i_smoothing_off,
   input wire        i_idle,
   input wire        i_trim_invalid,
   input wire        i_calibration_ok,
   input wire        i_status_defaults,
   input wire        i_enable_wr,
   input wire        i_read,
   input wire [2:0]  i_read_sel,
   input wire [15:0] o_read_data,
   input wire        o_read_valid,
   input wire        o_use_default_trim,
   input wire [3:0]  o_summary
);
   // ****************************************
   // Helper: cycles since operation levels moved
   // ****************************************
   wire [4:0] opr_lvl = {i_converting, i_await_start, i_smoothing_settled, i_smoothing_off,
                         i_idle};
   reg  [4:0] opr_prev;
   reg  [2:0] quiet_cnt;

   // Saturating quiet counter
   always @(posedge i_mclk) begin
      opr_prev <= opr_lvl;
      if (i_srst || opr_lvl != opr_prev) begin
         quiet_cnt <= 3'h0;
      end else if (quiet_cnt != 3'h7) begin
         quiet_cnt <= quiet_cnt + 3'h1;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   // ****************************************
   // Properties
   // ****************************************
   property p_valid_after_read; i_read |=> o_read_valid; endproperty
   a_valid_after_read: assert property (p_valid_after_read) else $error("read not answered");
   property p_opr_read_clears;
      (i_read && i_read_sel == 3'h1) ##2 (i_read && i_read_sel == 3'h1 && quiet_cnt >= 3'h5)
      |=> o_read_data == 16'h0000;
   endproperty
   a_opr_read_clears: assert property (p_opr_read_clears) else $error("event not cleared");
   property p_defaults_summary; i_status_defaults ##1 !i_enable_wr |=> o_summary == 4'h0; endproperty
   a_defaults_summary: assert property (p_defaults_summary) else $error("summary kept");
   property p_trim_flag; i_trim_invalid && !i_calibration_ok |=> o_use_default_trim; endproperty
   a_trim_flag: assert property (p_trim_flag) else $error("trim flag not set");
   property p_trim_hold; o_use_default_trim && !i_calibration_ok |=> o_use_default_trim; endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim flag dropped");
   property p_cal_clears; i_calibration_ok |=> !o_use_default_trim; endproperty
   a_cal_clears: assert property (p_cal_clears) else $error("trim flag stuck");
   property p_idle_live;
      i_read && i_read_sel == 3'h4 && $stable(i_idle) |=> o_read_data[10] == $past(i_idle);
   endproperty
   a_idle_live: assert property (p_idle_live) else $error("idle condition stale");
   property p_opr_unused;
      i_read && (i_read_sel == 3'h1 || i_read_sel == 3'h4) |=> (o_read_data & 16'hFACF) == 16'h0;
   endproperty
   a_opr_unused: assert property (p_opr_unused) else $error("unused bit set");
   c_read_std: cover property (i_read && i_read_sel == 3'h0 ##1 o_read_valid);
   c_defaults: cover property (i_status_defaults);
   c_cal: cover property (o_use_default_trim ##1 i_calibration_ok);
endmodule

bind sers_status_sets sers_status_sets_properties chk_i (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_converting(i_converting), .i_await_start(i_await_start),
   .i_smoothing_settled(i_smoothing_settled), .i_smoothing_off(i_smoothing_off),
   .i_idle(i_idle), .i_trim_invalid(i_trim_invalid), .i_calibration_ok(i_calibration_ok),
   .i_status_defaults(i_status_defaults), .i_enable_wr(i_enable_wr), .i_read(i_read),
   .i_read_sel(i_read_sel), .o_read_data(o_read_data), .o_read_valid(o_read_valid),
   .o_use_default_trim(o_use_default_trim), .o_summary(o_summary));

// ---- tb/sers_host_model.sv ----
// Host model issuing register reads, enable writes and clear commands
`timescale 1ns/1ns
module sers_host_model (
   input  wire        i_mclk,
   output reg         o_read,
   output reg  [2:0]  o_read_sel,
   output reg         o_enable_wr,
   output reg  [1:0]  o_enable_sel,
   output reg  [15:0] o_enable_data,
   output reg         o_clear_all,
   output reg         o_status_defaults
);
   // Idle command lines
   initial begin
      {o_read, o_enable_wr, o_clear_all, o_status_defaults} = 4'h0;
      o_read_sel = 3'h7;
      o_enable_sel = 2'h0;
      o_enable_data = 16'h0000;
   end

   // One read; released select shows the inverse
   task rd(input [2:0] sel);
      @(posedge i_mclk) #1 o_read = 1'b1;
      o_read_sel = sel;
      @(posedge i_mclk) #1 o_read = 1'b0;
      o_read_sel = ~sel;
   endtask

   // One enable register write
   task wr(input [1:0] sel, input [15:0] data);
      @(posedge i_mclk) #1 o_enable_wr = 1'b1;
      o_enable_sel = sel;
      o_enable_data = data;
      @(posedge i_mclk) #1 o_enable_wr = 1'b0;
      o_enable_sel = ~sel;
      o_enable_data = ~data;
   endtask

   // Clear-all (0) or status-defaults (1) pulse
   task cmd(input which);
      @(posedge i_mclk) #1 {o_status_defaults, o_clear_all} = which ? 2'h2 : 2'h1;
      @(posedge i_mclk) #1 {o_status_defaults, o_clear_all} = 2'h0;
   endtask
endmodule

// ---- tb/sers_status_sets_tb_top.sv ----
// Self-checking bench for the status register sets
`timescale 1ns/1ns
module sers_status_sets_tb_top;
   logic        i_mclk, srst, pend, bst, bclr, cal_ok, rd_s, en_wr, clr_all, defs;
   logic [23:0] cz;
   logic [2:0]  rd_sel, sel;
   logic [1:0]  en_sel;
   logic [15:0] en_data, o_read_data, ev, en;
   logic        o_read_valid, o_use_default_trim;
   logic [3:0]  o_summary, sm;
   logic [15:0] exp_q[$];
   int          fails, checked, i;
   int          bitpos[24] = '{0, 2, 3, 3, 4, 5, 5, 5, 6, 4, 5, 8, 8, 10, 0, 1, 2, 3, 4, 11, 5, 4,
                               14, 8};
   int          nst[6] = '{2, 1, 1, 2, 2, 1};
   logic [15:0] bexp[6] = '{16'h1080, 16'h0040, 16'h0100, 16'h2000, 16'h0200, 16'h0400};

   // ****************************************
   // Host model and design
   // ****************************************
   sers_host_model host (
      .i_mclk(i_mclk), .o_read(rd_s), .o_read_sel(rd_sel), .o_enable_wr(en_wr),
      .o_enable_sel(en_sel), .o_enable_data(en_data), .o_clear_all(clr_all),
      .o_status_defaults(defs));
   sers_status_sets #(.CNT_W(16)) uut (
      .i_mclk(i_mclk), .i_srst(srst), .i_completion_query(cz[0]), .i_ops_pending(pend),
      .i_empty_read_error(cz[1]), .i_err_resume_scan(cz[2]), .i_err_backup_lost(cz[3]),
      .i_run_fault(cz[4]), .i_err_setup_mismatch(cz[5]), .i_err_module_comm(cz[6]),
      .i_err_module_unsupported(cz[7]), .i_local_key(cz[8]), .i_converting(cz[9]),
      .i_await_start(cz[10]), .i_smoothing_settled(cz[11]), .i_smoothing_off(cz[12]),
      .i_idle(cz[13]), .i_over_range(cz[14]), .i_bound_hit(cz[18:15]), .i_hw_bound(cz[19]),
      .i_reading_done(cz[20]), .i_buffer_store(bst), .i_buffer_clear(bclr),
      .i_buffer_size(16'h0008), .i_notify_count(16'h0003), .i_junction_invalid(cz[21]),
      .i_trim_invalid(cz[23]), .i_calibration_ok(cal_ok), .i_param_ignored(cz[22]),
      .i_clear_all(clr_all), .i_status_defaults(defs), .i_enable_wr(en_wr),
      .i_enable_sel(en_sel), .i_enable_data(en_data), .i_read(rd_s), .i_read_sel(rd_sel),
      .o_read_data(o_read_data), .o_read_valid(o_read_valid),
      .o_use_default_trim(o_use_default_trim), .o_summary(o_summary));

   // Clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] expd);
      checked++;
      if (seen !== expd) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, expd, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task rd(input logic [2:0] s, input logic [15:0] v);
      exp_q.push_back(v);
      host.rd(s);
   endtask
   task pulse(input int k);
      cz[k] = 1'b1;
      tick(1);
      cz[k] = 1'b0;
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Read answer monitor against oldest expectation
   always @(negedge i_mclk) begin
      if (o_read_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("Error read data expected none seen %h", o_read_data);
         end else begin
            chk("read data", o_read_data, exp_q.pop_front());
         end
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge i_mclk);
      fails++;
      $display("Error watchdog expected end seen hang");
      stop_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {srst, pend, bst, bclr, cal_ok} = 5'h10;
      cz = 24'h000000;
      fails = 0;
      checked = 0;
      void'($urandom(32'hcc98));
      tick(8);
      srst = 1'b0;
      tick(4);
      rd(3'h0, 16'h0080);
      rd(3'h0, 16'h0000);
      for (i = 1; i < 4; i++) rd(i[2:0], 16'h0000);
      chk("summary", {12'h000, o_summary}, 16'h0000);
      $display("test power-up done");
      // Each of the 24 cz event sources with a random enable
      for (i = 0; i < 24; i++) begin
         sel = (i < 9) ? 3'h0 : (i < 14) ? 3'h1 : (i < 21) ? 3'h2 : 3'h3;
         ev = 16'h0001 << bitpos[i];
         if (i >= 15 && i <= 18) ev = ev | 16'h4000;
         en = 16'($urandom);
         host.wr(sel[1:0], en);
         cz[i] = 1'b1;
         tick(4);
         if (sel == 3'h1 || sel == 3'h3) rd(sel + 3'h3, ev);
         cz[i] = 1'b0;
         tick(4);
         sm = 4'h0;
         sm[sel] = |(ev & en);
         chk("summary", {12'h000, o_summary}, {12'h000, sm});
         rd(sel, ev);
         rd(sel, 16'h0000);
         tick(2);
         chk("summary", {12'h000, o_summary}, 16'h0000);
      end
      rd(3'h4, 16'h0000);
      chk("trim", {15'h0000, o_use_default_trim}, 16'h0001);
      cal_ok = 1'b1;
      tick(1);
      cal_ok = 1'b0;
      tick(3);
      rd(3'h6, 16'h0000);
      chk("trim", {15'h0000, o_use_default_trim}, 16'h0000);
      $display("test sources done");
      // Completion waits for pending work; set beats read-clear
      pend = 1'b1;
      pulse(0);
      tick(4);
      rd(3'h0, 16'h0000);
      pend = 1'b0;
      tick(4);
      rd(3'h0, 16'h0001);
      fork
         rd(3'h0, 16'h0000);
         begin tick(1); pulse(4); end
      join
      tick(2);
      rd(3'h0, 16'h0010);
      $display("test completion done");
      // Clear-all versus status-defaults
      host.wr(2'h0, 16'h00FF);
      pulse(4);
      tick(3);
      chk("summary", {12'h000, o_summary}, 16'h0001);
      host.cmd(1'b0);
      tick(3);
      chk("summary", {12'h000, o_summary}, 16'h0000);
      rd(3'h0, 16'h0000);
      pulse(4);
      tick(3);
      host.cmd(1'b1);
      tick(3);
      chk("summary", {12'h000, o_summary}, 16'h0000);
      rd(3'h0, 16'h0010);
      $display("test clears done");
      // Buffer levels, size 8, notify at 3
      bclr = 1'b1;
      tick(1);
      bclr = 1'b0;
      for (i = 0; i < 6; i++) begin
         repeat (nst[i]) begin
            bst = 1'b1;
            tick(1);
            bst = 1'b0;
            tick(1);
         end
         tick(3);
         rd(3'h2, bexp[i]);
      end
      rd(3'h5, 16'h33C0);
      $display("test buffer done");
      tick(4);
      chk("pending reads", 16'(exp_q.size()), 16'h0000);
      stop_test();
   end
endmodule
